// >>> hdl/pcr_clock_reset.sv
/*
 * Clock and reset generation unit: power-on pulse, brown-out reset output,
 * stretched system reset, loop control and glitch-free bypass switch, and
 * four clock generators.
 * Assumes all pins are synchronous to sys_clk; the analog loop, oscillator
 * and clock mux sit outside and obey the control outputs here.
 */
`timescale 1ns/10ps

module pcr_clk_div (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [7:0] div,
    output logic clk_out
);
    typedef struct packed {
        logic [7:0] cnt;
        logic q;
    } pcr_div_st_t;

    pcr_div_st_t st_reg;
    pcr_div_st_t st_next;

    // Half period of div cycles; zero behaves as one
    always_comb begin
        st_next = st_reg;
        if (!run) begin
            st_next.cnt = pcr_pkg::DIV_ZERO;
            st_next.q = 1'b0;
        end else if (st_reg.cnt + pcr_pkg::DIV_ONE >= div) begin
            st_next.cnt = pcr_pkg::DIV_ZERO;
            st_next.q = !st_reg.q;
        end else begin
            st_next.cnt = st_reg.cnt + pcr_pkg::DIV_ONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign clk_out = st_reg.q;
endmodule

module pcr_clock_reset (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic crystal_ref_in,
    input wire logic external_reset_in_n,
    input wire logic loop_supply_rail,
    input wire logic core_supply_rail,
    input wire logic pwm_supply_rail,
    input wire logic loop_lock_in,
    input wire logic fw_loop_enable,
    input wire logic fw_loop_select,
    input wire logic [3:0] fw_loop_mult,
    input wire logic [7:0] fw_core_div,
    input wire logic [7:0] fw_spdif_div,
    input wire logic [7:0] fw_adc_div,
    input wire logic [7:0] fw_mclk_div,
    output logic loop_ref_clk,
    output logic [3:0] loop_mult,
    output logic loop_enable,
    output logic osc_enable,
    output logic sys_clk_sel_loop,
    output logic sys_clk_gate_en,
    output logic pwm_clk_sel_loop,
    output logic por_pulse,
    output logic reset_output_n,
    output logic sys_reset_n,
    output logic core_clk_out,
    output logic spdif_clk_out,
    output logic adc_clk_out,
    output logic mclk_out
);
    typedef struct packed {
        logic ref_q;
        logic sup_q;
        logic por;
        logic [pcr_pkg::CNT_W-1:0] por_cnt;
        logic rst_out_n;
        logic sys_rst_n;
        logic [pcr_pkg::CNT_W-1:0] hold_cnt;
        logic loop_en;
        logic [3:0] mult;
        pcr_pkg::pcr_sw_state_t sw;
        logic [3:0] gap_cnt;
        logic sel;
        logic gate;
    } pcr_core_st_t;

    pcr_core_st_t st_reg;
    pcr_core_st_t st_next;
    logic in_rst;
    logic go_loop;

    assign in_rst = !external_reset_in_n || !st_reg.sys_rst_n;
    // Loop use needs firmware request, enable and lock all together
    assign go_loop = st_reg.loop_en && fw_loop_select && loop_lock_in;

    always_comb begin
        st_next = st_reg;
        st_next.ref_q = crystal_ref_in;
        st_next.sup_q = loop_supply_rail;

        // Pulse on every rise of the loop supply, incl. after a droop
        if (loop_supply_rail && !st_reg.sup_q) begin
            st_next.por = 1'b1;
            st_next.por_cnt = pcr_pkg::POR_PULSE_CNT;
        end else if (!loop_supply_rail) begin
            st_next.por = 1'b0;
        end else if (st_reg.por) begin
            if (st_reg.por_cnt == pcr_pkg::CNT_ZERO) begin
                st_next.por = 1'b0;
            end else begin
                st_next.por_cnt = st_reg.por_cnt - 1'b1;
            end
        end

        st_next.rst_out_n = !(st_next.por || !core_supply_rail || !pwm_supply_rail);

        // Stretch restarts while any source is active
        if (!external_reset_in_n || st_reg.por) begin
            st_next.sys_rst_n = 1'b0;
            st_next.hold_cnt = pcr_pkg::RST_HOLD_CNT;
        end else if (st_reg.hold_cnt != pcr_pkg::CNT_ZERO) begin
            st_next.hold_cnt = st_reg.hold_cnt - 1'b1;
        end else begin
            st_next.sys_rst_n = 1'b1;
        end

        st_next.loop_en = !in_rst && fw_loop_enable;

        // Multiplier only moves while bypassed, so a loop in use as clock source never steps
        if (st_reg.sw == pcr_pkg::PCR_SW_BYP) begin
            if (fw_loop_mult < pcr_pkg::MULT_MIN) begin
                st_next.mult = pcr_pkg::MULT_MIN;
            end else begin
                st_next.mult = fw_loop_mult;
            end
        end

        unique case (st_reg.sw)
            pcr_pkg::PCR_SW_BYP: begin
                if (go_loop) begin
                    st_next.sw = pcr_pkg::PCR_SW_GAP_IN;
                    st_next.gap_cnt = pcr_pkg::SW_GAP_CNT;
                end
            end
            pcr_pkg::PCR_SW_GAP_IN: begin
                if (!go_loop) begin
                    st_next.sw = pcr_pkg::PCR_SW_GAP_OUT;
                    st_next.gap_cnt = pcr_pkg::SW_GAP_CNT;
                end else if (st_reg.gap_cnt == 4'h0) begin
                    st_next.sw = pcr_pkg::PCR_SW_LOOP;
                end else begin
                    st_next.gap_cnt = st_reg.gap_cnt - 1'b1;
                end
                if (go_loop && st_reg.gap_cnt == pcr_pkg::SW_GAP_HALF) begin
                    st_next.sel = 1'b1;
                end
            end
            pcr_pkg::PCR_SW_LOOP: begin
                if (!go_loop) begin
                    st_next.sw = pcr_pkg::PCR_SW_GAP_OUT;
                    st_next.gap_cnt = pcr_pkg::SW_GAP_CNT;
                end
            end
            pcr_pkg::PCR_SW_GAP_OUT: begin
                if (st_reg.gap_cnt == 4'h0) begin
                    st_next.sw = pcr_pkg::PCR_SW_BYP;
                end else begin
                    st_next.gap_cnt = st_reg.gap_cnt - 1'b1;
                end
                if (st_reg.gap_cnt == pcr_pkg::SW_GAP_HALF) begin
                    st_next.sel = 1'b0;
                end
            end
        endcase

        // Reset forces bypass at once; the mux is gated, so no runt pulse
        if (in_rst) begin
            st_next.sw = pcr_pkg::PCR_SW_BYP;
            st_next.sel = 1'b0;
        end
        // Any select move, forced ones too, keeps the gate shut for that cycle
        st_next.gate = ((st_next.sw == pcr_pkg::PCR_SW_BYP) ||
            (st_next.sw == pcr_pkg::PCR_SW_LOOP)) &&
            (st_next.sel == st_reg.sel);
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_reg <= '0;
            st_reg.rst_out_n <= 1'b0;
            st_reg.mult <= pcr_pkg::MULT_RESET;
            st_reg.sw <= pcr_pkg::PCR_SW_BYP;
            st_reg.gate <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign loop_ref_clk = st_reg.ref_q;
    assign loop_mult = st_reg.mult;
    assign loop_enable = st_reg.loop_en;
    assign osc_enable = 1'b1;
    assign sys_clk_sel_loop = st_reg.sel;
    assign sys_clk_gate_en = st_reg.gate;
    assign pwm_clk_sel_loop = st_reg.sel;
    assign por_pulse = st_reg.por;
    assign reset_output_n = st_reg.rst_out_n;
    assign sys_reset_n = st_reg.sys_rst_n;

    // Generators follow the selected system clock, held while in reset
    pcr_clk_div u_core_div (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(st_reg.sys_rst_n),
        .div(fw_core_div),
        .clk_out(core_clk_out)
    );
    pcr_clk_div u_spdif_div (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(st_reg.sys_rst_n),
        .div(fw_spdif_div),
        .clk_out(spdif_clk_out)
    );
    pcr_clk_div u_adc_div (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(st_reg.sys_rst_n),
        .div(fw_adc_div),
        .clk_out(adc_clk_out)
    );
    pcr_clk_div u_mclk_div (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(st_reg.sys_rst_n),
        .div(fw_mclk_div),
        .clk_out(mclk_out)
    );

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    localparam int SWITCH_BOUND = 12;

    sequence ext_release_s;
        $rose(external_reset_in_n) && !por_pulse;
    endsequence
    sequence held_low_s;
        !sys_reset_n [*8];
    endsequence

    chk_ref_follow: assert property (
        $past(rstn) |-> loop_ref_clk == $past(crystal_ref_in))
        else $error("reference not passed to loop");
    chk_mult_range: assert property (
        loop_mult >= pcr_pkg::MULT_MIN && loop_mult <= pcr_pkg::MULT_MAX)
        else $error("multiplier out of range");
    chk_bypass_nolock: assert property (
        !loop_lock_in |-> ##[1:SWITCH_BOUND] !sys_clk_sel_loop)
        else $error("loop clock kept without lock");
    chk_pwm_source: assert property (
        pwm_clk_sel_loop == sys_clk_sel_loop) else $error("PWM clock source differs");
    chk_mult_fw_only: assert property (
        ##1 $changed(loop_mult) |-> $past(fw_loop_mult) == loop_mult || loop_mult == pcr_pkg::MULT_MIN)
        else $error("multiplier changed without firmware");
    chk_por_rise: assert property (
        $rose(loop_supply_rail) ##1 loop_supply_rail |-> por_pulse)
        else $error("no power-on pulse on supply rise");
    chk_por_output: assert property (
        por_pulse |-> !reset_output_n) else $error("reset output high during power-on pulse");
    chk_brownout_out: assert property (
        (!core_supply_rail || !pwm_supply_rail) |=> !reset_output_n)
        else $error("brown-out did not pull reset output");
    chk_ext_start: assert property (
        !external_reset_in_n |=> !sys_reset_n) else $error("external reset not applied");
    chk_stretch_hold: assert property (
        ext_release_s |-> held_low_s) else $error("internal reset released too early");
    chk_ext_state: assert property (
        !external_reset_in_n |=> !loop_enable && osc_enable && !sys_clk_sel_loop)
        else $error("reset condition not kept");
    chk_switch_gap: assert property (
        $changed(sys_clk_sel_loop) |-> !sys_clk_gate_en &&
        ($past(sys_clk_gate_en, 4) == 1'b0 || $past(in_rst) == 1'b1))
        else $error("clock select moved with gate open");
    chk_div_held: assert property (
        !sys_reset_n |=> !core_clk_out && !spdif_clk_out && !adc_clk_out && !mclk_out)
        else $error("clock generator ran in reset");
    chk_loop_enable: assert property (
        !in_rst |=> loop_enable == $past(fw_loop_enable))
        else $error("loop enable not following firmware");
    chk_mult_hold: assert property (
        sys_clk_sel_loop |=> $stable(loop_mult))
        else $error("multiplier moved while loop in use");
endmodule

// >>> hdl/pcr_pkg.sv
/*
 * Constants, types and timing figures for the clock and reset generation unit.
 * Assumes a single 100 MHz system clock and synchronous, active-low reset.
 */
// Overview of operation
// - Loop reference is taken from the crystal reference input.
// - Loop multiplier is a firmware integer, held within 4 to 15.
// - Logic runs from the reference until the loop is configured and locked.
// - Loop output times the PWM outputs and derives the core clock.
// - Clock generators produce core, S/PDIF, ADC and master clock outputs.
// - Loop settings change only by firmware request, never autonomously.
// - Power-on pulse on each rise of the loop supply above threshold.
// - Active power-on reset drives the reset output low.
// - Core or PWM supply brown-out drives the reset output low.
// - System reset starts on external reset low or power-on pulse.
// - Counter stretches internal reset in time and cycles after release.
// - During external reset: all resets active, oscillator on, loop off; reset_output_n does not follow external reset here.
package pcr_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int CNT_W = 12;

    // Power-on pulse width, least time
    localparam int unsigned POR_PULSE_NS = 200;
    localparam int unsigned POR_PULSE_CYC = (POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] POR_PULSE_CNT = CNT_W'(POR_PULSE_CYC - 1);

    // Internal reset stretch: both a least time and a least cycle count
    localparam int unsigned RST_HOLD_NS = 10000;
    localparam int unsigned RST_HOLD_TIME_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_HOLD_MIN_CYC = 256;
    localparam int unsigned RST_HOLD_CYC = (RST_HOLD_TIME_CYC > RST_HOLD_MIN_CYC) ?
        RST_HOLD_TIME_CYC : RST_HOLD_MIN_CYC;
    localparam logic [CNT_W-1:0] RST_HOLD_CNT = CNT_W'(RST_HOLD_CYC - 1);

    // Clock switch dead gap, select flips halfway through it
    localparam logic [3:0] SW_GAP_CNT = 4'h7;
    localparam logic [3:0] SW_GAP_HALF = 4'h3;

    localparam logic [3:0] MULT_MIN = 4'h4;
    localparam logic [3:0] MULT_MAX = 4'hF;
    localparam logic [3:0] MULT_RESET = 4'h4;

    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [7:0] DIV_ZERO = 8'h00;
    localparam logic [7:0] DIV_ONE = 8'h01;

    typedef enum logic [1:0] {
        PCR_SW_BYP = 2'b00,
        PCR_SW_GAP_IN = 2'b01,
        PCR_SW_LOOP = 2'b10,
        PCR_SW_GAP_OUT = 2'b11
    } pcr_sw_state_t;
endpackage

// >>> verif/pcr_clock_reset_test.sv
/*
 * Self-checking bench for the clock and reset unit.
 * Assumes the reference model drives the crystal and external reset pins.
 */
`timescale 1ns/10ps
module pcr_clock_reset_test;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic hold_rst = 1'b1;
    logic loop_sup = 1'b0;
    logic core_sup = 1'b1;
    logic pwm_sup = 1'b1;
    logic lock = 1'b0;
    logic fw_en = 1'b1;
    logic fw_sel = 1'b0;
    logic [3:0] mult_in = 4'h0;
    // Mclk divider left at 0 to see it act as 1
    logic [31:0] divs = 32'h0004_0302;
    logic xtal, ext_n, ref_o, en_o, osc_o, sel_o, gate_o, psel_o, por_o, rout_n, srst_n;
    logic [3:0] mult_o;
    logic [3:0] clk_o;
    int failures = 0;
    int checks_done = 0;

    always #5 sys_clk = ~sys_clk;

    pcr_ref_model ref_u (.sys_clk(sys_clk), .hold_rst(hold_rst),
        .crystal_ref_in(xtal), .external_reset_in_n(ext_n));

    pcr_clock_reset dut_u (.sys_clk(sys_clk), .rstn(rstn), .crystal_ref_in(xtal),
        .external_reset_in_n(ext_n), .loop_supply_rail(loop_sup),
        .core_supply_rail(core_sup), .pwm_supply_rail(pwm_sup), .loop_lock_in(lock),
        .fw_loop_enable(fw_en), .fw_loop_select(fw_sel), .fw_loop_mult(mult_in),
        .fw_core_div(divs[7:0]), .fw_spdif_div(divs[15:8]), .fw_adc_div(divs[23:16]),
        .fw_mclk_div(divs[31:24]), .loop_ref_clk(ref_o), .loop_mult(mult_o),
        .loop_enable(en_o), .osc_enable(osc_o), .sys_clk_sel_loop(sel_o),
        .sys_clk_gate_en(gate_o), .pwm_clk_sel_loop(psel_o), .por_pulse(por_o),
        .reset_output_n(rout_n), .sys_reset_n(srst_n), .core_clk_out(clk_o[0]),
        .spdif_clk_out(clk_o[1]), .adc_clk_out(clk_o[2]), .mclk_out(clk_o[3]));

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic pick(input int i);
        case (i)
            0: return gate_o;
            1: return sel_o;
            2: return srst_n;
            default: return rout_n;
        endcase
    endfunction

    task automatic wait_val(input int i, input logic v, input int lim);
        int n;
        n = 0;
        while (pick(i) !== v && n < lim) begin
            cyc(1);
            n++;
        end
        chk_bit(pick(i), v, "bounded wait ran out");
    endtask

    task automatic t_ext_reset();
        @(posedge sys_clk) hold_rst <= 1'b1;
        cyc(2);
        chk_bit(srst_n, 1'b0, "internal reset not active");
        chk_bit(en_o, 1'b0, "loop enabled in reset");
        chk_bit(osc_o, 1'b1, "oscillator off in reset");
        chk_bit(sel_o, 1'b0, "loop selected in reset");
        @(posedge sys_clk) hold_rst <= 1'b0;
        cyc(pcr_pkg::RST_HOLD_CYC - 1);
        chk_bit(srst_n, 1'b0, "internal reset released early");
        wait_val(2, 1'b1, 1);
        $display("test ext_reset done");
    endtask

    task automatic t_por();
        repeat (2) begin
            @(posedge sys_clk) loop_sup <= 1'b0;
            cyc(3);
            @(posedge sys_clk) loop_sup <= 1'b1;
            cyc(2);
            chk_bit(por_o, 1'b1, "no power-on pulse");
            cyc(1);
            chk_bit(rout_n, 1'b0, "reset out high during pulse");
            cyc(pcr_pkg::POR_PULSE_CYC - 3);
            chk_bit(por_o, 1'b1, "pulse too short");
            cyc(1);
            chk_bit(por_o, 1'b0, "pulse too long");
            chk_bit(srst_n, 1'b0, "pulse left system reset off");
            wait_val(3, 1'b1, 3);
            wait_val(2, 1'b1, 1010);
        end
        $display("test por done");
    endtask

    task automatic t_brownout();
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            if (i == 0) core_sup <= 1'b0;
            else pwm_sup <= 1'b0;
            cyc(2);
            chk_bit(rout_n, 1'b0, "brown-out ignored");
            @(posedge sys_clk) core_sup <= 1'b1;
            pwm_sup <= 1'b1;
            cyc(2);
            chk_bit(rout_n, 1'b1, "reset out stuck low");
        end
        $display("test brownout done");
    endtask

    task automatic t_loop();
        logic r;
        for (int v = 0; v < 16; v++) begin
            @(posedge sys_clk) mult_in <= 4'(v);
            cyc(2);
            chk_nib(mult_o, (v < 4) ? 4'h4 : 4'(v), "multiplier");
        end
        @(posedge sys_clk) fw_en <= 1'b0;
        cyc(2);
        chk_bit(en_o, 1'b0, "loop enable not removed");
        @(posedge sys_clk) fw_en <= 1'b1;
        cyc(2);
        chk_bit(en_o, 1'b1, "loop enable not applied");
        repeat (8) begin
            r = xtal;
            cyc(1);
            chk_bit(ref_o, r, "loop reference");
        end
        $display("test loop done");
    endtask

    task automatic t_switch();
        @(posedge sys_clk) fw_sel <= 1'b1;
        cyc(20);
        chk_bit(sel_o, 1'b0, "switched without lock");
        @(posedge sys_clk) lock <= 1'b1;
        wait_val(0, 1'b0, 4);
        wait_val(1, 1'b1, 8);
        chk_bit(gate_o, 1'b0, "select moved with clock on");
        wait_val(0, 1'b1, 8);
        chk_bit(psel_o, 1'b1, "pwm not on loop");
        @(posedge sys_clk) mult_in <= 4'h9;
        cyc(3);
        chk_nib(mult_o, 4'hF, "multiplier changed on loop");
        @(posedge sys_clk) lock <= 1'b0;
        wait_val(1, 1'b0, 10);
        chk_bit(gate_o, 1'b0, "select moved with clock on");
        wait_val(0, 1'b1, 8);
        @(posedge sys_clk) lock <= 1'b1;
        wait_val(1, 1'b1, 16);
        wait_val(0, 1'b1, 8);
        @(posedge sys_clk) hold_rst <= 1'b1;
        cyc(1);
        chk_bit(sel_o, 1'b0, "loop kept in reset");
        chk_bit(gate_o, 1'b0, "forced switch not gated");
        @(posedge sys_clk) hold_rst <= 1'b0;
        wait_val(2, 1'b1, 1010);
        $display("test switch done");
    endtask

    task automatic t_div();
        logic c;
        int n;
        int exp_half [4];
        exp_half = '{2, 3, 4, 1};
        for (int i = 0; i < 4; i++) begin
            repeat (2) begin
                c = clk_o[i];
                n = 0;
                while (clk_o[i] === c && n < 20) begin
                    cyc(1);
                    n++;
                end
            end
            chk_nib(4'(n), 4'(exp_half[i]), "divider half period");
        end
        $display("test div done");
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Whole run is near 4200 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("ERROR %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        t_ext_reset();
        t_por();
        t_brownout();
        t_loop();
        t_switch();
        t_div();
        summarize();
    end
endmodule

// >>> verif/pcr_ref_model.sv
/*
 * Far-side model: free-running crystal reference and external reset circuit.
 * Assumes the bench asks for external reset through hold_rst.
 */
`timescale 1ns/10ps
module pcr_ref_model #(
    parameter int HALF = 3
) (
    input wire logic sys_clk,
    input wire logic hold_rst,
    output logic crystal_ref_in,
    output logic external_reset_in_n
);
    int half_cnt_reg = 0;
    initial crystal_ref_in = 1'b0;
    // Oscillator never stops, not even in reset
    always @(posedge sys_clk) begin
        if (half_cnt_reg == HALF - 1) begin
            half_cnt_reg <= 0;
            crystal_ref_in <= ~crystal_ref_in;
        end else begin
            half_cnt_reg <= half_cnt_reg + 1;
        end
    end
    assign external_reset_in_n = ~hold_rst;
endmodule
